// ===== include/pax_map.vh
// Register map, field positions and reset values of the port auxiliary block.
// Assumes a 32-bit AHB-Lite slave with one register per aligned word.
`ifndef PAX_MAP_VH
`define PAX_MAP_VH

// Register byte offsets
`define PAX_OFS_ANA_LO      8'h00
`define PAX_OFS_ANA_HI      8'h04
`define PAX_OFS_PULLUP      8'h08
`define PAX_OFS_CHG_EN      8'h0C
`define PAX_OFS_CTRL        8'h10
`define PAX_OFS_PORT        8'h14
`define PAX_OFS_DIR         8'h18
`define PAX_OFS_STAT        8'h1C

// Decoded address bits
`define PAX_ADDR_W          8

// Reset values
`define PAX_RST_ANA_LO      8'hFF
`define PAX_RST_ANA_HI      4'hF
`define PAX_RST_PULLUP      6'h37
`define PAX_RST_CHG_EN      6'h00
`define PAX_RST_DIR         6'h3F
`define PAX_RST_OUT         6'h00

// Implemented pull-up bits and the bits that read as one in crystal modes
`define PAX_PULLUP_MASK     6'h37
`define PAX_XTAL_MASK       6'h30

// Control register fields
`define PAX_CTRL_PU_DIS     0
`define PAX_CTRL_GIE        1
`define PAX_CTRL_LPW_EN     2

// Status register fields
`define PAX_STAT_FLAG       0
`define PAX_STAT_MISM       1
`define PAX_STAT_SLEEP      2

// Pin roles
`define PAX_PIN_DED         3
`define PAX_PIN_WAKE        0

// Change-interrupt vector address
`define PAX_INT_VECTOR      16'h0004

// AHB-Lite codes
`define PAX_HTRANS_NONSEQ   2'b10
`define PAX_HRESP_OKAY      1'b0

`endif

// ===== verilog/pax_port_aux.v
// Auxiliary logic of a six-pin port: weak pull-ups, change detection with
// a shared flag, analog select gating and the low-power wake current sink.
// Assumes pins already synchronous to hclk; registers reached over AHB-Lite
// with a single slave, zero wait states, whole-word transfers only.
`include "pax_map.vh"

// How it works
// - Pins 0,1,2,4,5 each have a weak pull-up enabled by its own bit.
// - A pull-up is forced off while that pin is an output.
// - Pull-ups need the global gate; power-on reset leaves them all disabled.
// - Dedicated input pin pull-up follows master-clear mode only, no software control.
// - Pull-up register holds bits 5,4,2,1,0; bits 7,6,3 read zero.
// - In crystal modes pull-up bits 5 and 4 read as one.
// - Six change-interrupt enables, one per pin, cleared on power-on reset.
// - Enabled pins are compared with the last-read latch; mismatches ORed set flag.
// - A lasting mismatch keeps setting the flag; a port read relatches the pins.
// - Master-clear and brown-out resets keep the latch and the flag but clear the change enables.
// - A change coinciding with a port read is compared with the old latch and still sets the flag.
// - A port change condition wakes the device from sleep.
// - In crystal modes change-enable bits 5 and 4 read as one.
// - The change interrupt is recognised only with global interrupt enable set.
// - An analog-selected pin loses digital input, pull-up and change detection.
// - Cleared analog bit means digital; high register has four bits, 7-4 read zero.
// - Low-power wake enable turns on the current sink on pin 0.
// - Pin 0 falling below threshold wakes; with global enable it vectors to 0004h.
// - Analog-selected pins read zero on every digital port read.
// - Direction one makes a pin an input, zero an output.
module pax_port_aux #(
	parameter NPIN = 6
) (
	// Clock and resets
	input  wire                  hclk,
	input  wire                  hresetn,
	input  wire                  soft_rst,
	// AHB-Lite slave
	input  wire                  hsel,
	input  wire [31:0]           haddr,
	input  wire [1:0]            htrans,
	input  wire                  hwrite,
	input  wire [2:0]            hsize,
	input  wire [31:0]           hwdata,
	input  wire                  hready,
	output wire                  hreadyout,
	output wire                  hresp,
	output reg  [31:0]           hrdata,
	// Device configuration and core state
	input  wire                  cfg_master_clear,
	input  wire                  cfg_crystal_mode,
	input  wire                  sleep_mode,
	// Pins
	input  wire [NPIN-1:0]       pin_in,
	output reg  [NPIN-1:0]       pin_out,
	output reg  [NPIN-1:0]       pin_oe,
	output reg  [NPIN-1:0]       pullup_on,
	output reg                   wake_sink_on,
	// Core requests
	output wire                  int_req,
	output wire                  wake_req
);

	// Map analog select bits onto port pins: AN0-2 on pins 0-2, AN3 on pin 4
	function [NPIN-1:0] ana_of_pin;
		input [7:0] ana_lo;
		begin
			ana_of_pin = {1'b0, ana_lo[3], 1'b0, ana_lo[2], ana_lo[1], ana_lo[0]};
		end
	endfunction

	// Software registers
	reg [7:0]      ana_lo_q;
	reg [3:0]      ana_hi_q;
	reg [NPIN-1:0] pullup_q;
	reg [NPIN-1:0] chg_en_q;
	reg [NPIN-1:0] dir_q;
	reg [NPIN-1:0] out_q;
	reg            pu_dis_q;
	reg            gie_q;
	reg            lpw_en_q;
	// Change detection state
	reg [NPIN-1:0] last_rd_q;
	reg            flag_q;
	// Bus data phase
	reg            wr_pend_q;
	reg [7:0]      wr_addr_q;

	wire [NPIN-1:0] ana_pin;
	wire [NPIN-1:0] pin_dig;
	wire [NPIN-1:0] chg_live;
	wire [NPIN-1:0] mism_vec;
	wire            mism_any;
	wire            addr_ph;
	wire [7:0]      addr_lo;
	wire            rd_port;
	wire            wr_port;
	wire            wr_stat;
	wire [NPIN-1:0] xtal_rd;
	reg  [31:0]     rd_mux;

	assign ana_pin  = ana_of_pin(ana_lo_q);
	// Digital input path: analog pins and the master-clear pin read zero
	assign pin_dig  = pin_in & ~ana_pin &
		~({{(NPIN-1){1'b0}}, cfg_master_clear} << `PAX_PIN_DED);
	assign chg_live = chg_en_q & ~ana_pin;
	assign mism_vec = (pin_dig ^ last_rd_q) & chg_live;
	assign mism_any = |mism_vec;

	// Bus decode
	assign addr_ph  = hsel & hready & (htrans == `PAX_HTRANS_NONSEQ);
	assign addr_lo  = haddr[7:0];
	assign rd_port  = addr_ph & ~hwrite & (addr_lo == `PAX_OFS_PORT);
	assign wr_port  = wr_pend_q & (wr_addr_q == `PAX_OFS_PORT);
	assign wr_stat  = wr_pend_q & (wr_addr_q == `PAX_OFS_STAT) & hwdata[`PAX_STAT_FLAG];
	assign xtal_rd  = cfg_crystal_mode ? `PAX_XTAL_MASK : {NPIN{1'b0}};
	assign hreadyout = 1'b1;
	assign hresp     = `PAX_HRESP_OKAY;

	// Read data selected in the address phase, held in the data phase
	always @* begin
		rd_mux = 32'h0000_0000;
		case (addr_lo)
			`PAX_OFS_ANA_LO: rd_mux[7:0] = ana_lo_q;
			`PAX_OFS_ANA_HI: rd_mux[3:0] = ana_hi_q;
			`PAX_OFS_PULLUP: rd_mux[NPIN-1:0] =
				(pullup_q | xtal_rd) & `PAX_PULLUP_MASK;
			`PAX_OFS_CHG_EN: rd_mux[NPIN-1:0] = chg_en_q | xtal_rd;
			`PAX_OFS_CTRL: begin
				rd_mux[`PAX_CTRL_PU_DIS] = pu_dis_q;
				rd_mux[`PAX_CTRL_GIE]    = gie_q;
				rd_mux[`PAX_CTRL_LPW_EN] = lpw_en_q;
			end
			`PAX_OFS_PORT: rd_mux[NPIN-1:0] = pin_dig;
			`PAX_OFS_DIR: rd_mux[NPIN-1:0] =
				dir_q | xtal_rd | ({{(NPIN-1){1'b0}}, 1'b1} << `PAX_PIN_DED);
			`PAX_OFS_STAT: begin
				rd_mux[`PAX_STAT_FLAG]  = flag_q;
				rd_mux[`PAX_STAT_MISM]  = mism_any;
				rd_mux[`PAX_STAT_SLEEP] = sleep_mode;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata    <= 32'h0000_0000;
		end else begin
			wr_pend_q <= addr_ph & hwrite;
			if (addr_ph) begin
				wr_addr_q <= addr_lo;
			end
			if (addr_ph & ~hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	// Configuration registers; master-clear and brown-out restore the same values except out_q, which they keep
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ana_lo_q <= `PAX_RST_ANA_LO;
			ana_hi_q <= `PAX_RST_ANA_HI;
			pullup_q <= `PAX_RST_PULLUP;
			chg_en_q <= `PAX_RST_CHG_EN;
			dir_q    <= `PAX_RST_DIR;
			out_q    <= `PAX_RST_OUT;
			pu_dis_q <= 1'b1;
			gie_q    <= 1'b0;
			lpw_en_q <= 1'b0;
		end else if (soft_rst) begin
			ana_lo_q <= `PAX_RST_ANA_LO;
			ana_hi_q <= `PAX_RST_ANA_HI;
			pullup_q <= `PAX_RST_PULLUP;
			chg_en_q <= `PAX_RST_CHG_EN;
			dir_q    <= `PAX_RST_DIR;
			pu_dis_q <= 1'b1;
			gie_q    <= 1'b0;
			lpw_en_q <= 1'b0;
		end else if (wr_pend_q) begin
			case (wr_addr_q)
				`PAX_OFS_ANA_LO: ana_lo_q <= hwdata[7:0];
				`PAX_OFS_ANA_HI: ana_hi_q <= hwdata[3:0];
				`PAX_OFS_PULLUP: pullup_q <= hwdata[NPIN-1:0] & `PAX_PULLUP_MASK;
				`PAX_OFS_CHG_EN: chg_en_q <= hwdata[NPIN-1:0];
				`PAX_OFS_CTRL: begin
					pu_dis_q <= hwdata[`PAX_CTRL_PU_DIS];
					gie_q    <= hwdata[`PAX_CTRL_GIE];
					lpw_en_q <= hwdata[`PAX_CTRL_LPW_EN];
				end
				`PAX_OFS_PORT: out_q <= hwdata[NPIN-1:0];
				`PAX_OFS_DIR:  dir_q <= hwdata[NPIN-1:0];
				default: ;
			endcase
		end
	end

	// Last-read latch: only power-on clears it; any port access relatches it.
	// A change landing in the read cycle is compared against the old value,
	// so it still sets the flag and no window is lost.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_rd_q <= {NPIN{1'b0}};
		end else if (rd_port | wr_port) begin
			last_rd_q <= pin_dig;
		end
	end

	// Shared change flag: a mismatch in the clearing cycle wins over the clear
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= mism_any | (flag_q & ~wr_stat);
		end
	end

	assign int_req  = flag_q & gie_q;
	assign wake_req = sleep_mode & (flag_q | mism_any);

	// Pin drivers and pull-ups
	genvar i;
	generate
		for (i = 0; i < NPIN; i = i + 1) begin : g_pin
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pin_out[i]   <= 1'b0;
					pin_oe[i]    <= 1'b0;
					pullup_on[i] <= 1'b0;
				end else if (i == `PAX_PIN_DED) begin
					pin_out[i]   <= 1'b0;
					pin_oe[i]    <= 1'b0;
					pullup_on[i] <= cfg_master_clear;
				end else begin
					pin_out[i]   <= out_q[i];
					pin_oe[i]    <= ~dir_q[i];
					pullup_on[i] <= pullup_q[i] & dir_q[i] & ~pu_dis_q
						& ~ana_pin[i];
				end
			end
		end
	endgenerate

	// Current sink on pin 0 for RC-timed wake-up
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_sink_on <= 1'b0;
		end else begin
			wake_sink_on <= lpw_en_q;
		end
	end

endmodule

// ===== test/pax_port_aux_checker.sv
// Concurrent checks on the pins and core requests of the port auxiliary block.
// Assumes it is bound to pax_port_aux and sees only that module's ports.
module pax_port_aux_checker #(
	parameter NPIN = 6
) (
	// Clock, reset and bus
	input wire            hclk,
	input wire            hresetn,
	input wire            hsel,
	input wire [1:0]      htrans,
	input wire            hready,
	// Core and pins
	input wire            cfg_master_clear,
	input wire            sleep_mode,
	input wire [NPIN-1:0] pin_out,
	input wire [NPIN-1:0] pin_oe,
	input wire [NPIN-1:0] pullup_on,
	input wire            int_req,
	input wire            wake_req
);
	timeunit 1ns;
	timeprecision 1ps;
	reg  [1:0] up_q;
	wire       acc;
	assign acc = hsel && htrans[1] && hready;
	// Marks the first two edges after power-on reset
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			up_q <= 2'h0;
		else
			up_q <= {up_q[0], 1'h1};
	end
	default clocking dc @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence quiet_wake;
		wake_req && !acc && !$past(acc);
	endsequence
	sequence still_asleep;
		sleep_mode;
	endsequence
	a_pullup_out_off: assert property ((pullup_on & pin_oe) == 0)
		else $error("pull-up on a driven pin");
	a_ded_pullup: assert property (up_q[1] && $stable(cfg_master_clear)
		|-> pullup_on[3] == cfg_master_clear) else $error("pin 3 pull-up wrong");
	a_por_pullups: assert property (!up_q[1] |-> (pullup_on & 6'h37) == 0)
		else $error("pull-up on after reset");
	a_por_no_wake: assert property (!up_q[1] |-> !wake_req)
		else $error("wake after reset");
	a_por_no_int: assert property (!up_q[1] |-> !int_req)
		else $error("request after reset");
	a_wake_sleep: assert property (wake_req |-> sleep_mode)
		else $error("wake while awake");
	a_pin3_input: assert property (!pin_oe[3] && !pin_out[3])
		else $error("pin 3 driven");
	a_flag_sticky: assert property (quiet_wake ##1 still_asleep |-> wake_req)
		else $error("flag lost");
endmodule
bind pax_port_aux pax_port_aux_checker #(.NPIN(NPIN)) pax_port_aux_checker_inst (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
	.cfg_master_clear(cfg_master_clear), .sleep_mode(sleep_mode), .pin_out(pin_out),
	.pin_oe(pin_oe), .pullup_on(pullup_on), .int_req(int_req), .wake_req(wake_req));

// ===== test/pax_pins.sv
// Pin model: bench drivers, pull-ups, floating pins and an RC on pin 0.
// Assumes the port block's pin outputs; pin 0 carries only the capacitor.
module pax_pins (
	// Block side
	input wire       hclk,
	input wire [5:0] pin_out,
	input wire [5:0] pin_oe,
	input wire [5:0] pullup_on,
	input wire       wake_sink_on,
	// Bench side
	input wire [5:0] ext_val,
	input wire [5:0] ext_en,
	output reg [5:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	reg     [3:0] cap_q = 4'h0;
	reg     [5:0] flt_q = 6'h0;
	integer       i;
	always @(posedge hclk) begin
		flt_q <= ~flt_q;
		if (pin_oe[0])
			cap_q <= pin_out[0] ? 4'hF : 4'h0;
		else if (wake_sink_on && cap_q != 4'h0)
			cap_q <= cap_q - 4'h1;
	end
	// Undriven pins 1-5 float to a changing level unless pulled up; undriven pin 0 follows the capacitor
	always @* begin
		for (i = 1; i < 6; i = i + 1)
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
				pullup_on[i] | flt_q[i];
		pin_in[0] = pin_oe[0] ? pin_out[0] : cap_q[3];
	end
endmodule

// ===== test/tb_top.sv
// Bench for the port auxiliary block: AHB-Lite register tasks and pin scenarios.
// Assumes pax_port_aux, the pin model pax_pins and the bound checker.
`include "pax_map.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	reg         hclk = 1'h0, hresetn = 1'h0, soft_rst = 1'h0, hwrite = 1'h0;
	reg         mc = 1'h0, xtal = 1'h0, sleep_mode = 1'h0;
	reg  [1:0]  htrans = 2'h0;
	reg  [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	reg  [5:0]  ext_val = 6'h3F;
	wire        hreadyout, hresp, wake_sink_on, int_req, wake_req;
	wire [31:0] hrdata;
	wire [5:0]  pin_in, pin_out, pin_oe, pullup_on;
	integer     err_total = 0, checks = 0, cyc = 0;
	pax_port_aux pax_port_aux_inst (.hclk(hclk), .hresetn(hresetn), .soft_rst(soft_rst),
		.hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .cfg_master_clear(mc), .cfg_crystal_mode(xtal),
		.sleep_mode(sleep_mode), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pullup_on(pullup_on), .wake_sink_on(wake_sink_on), .int_req(int_req),
		.wake_req(wake_req));
	pax_pins pax_pins_inst (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pullup_on(pullup_on), .wake_sink_on(wake_sink_on), .ext_val(ext_val),
		.ext_en(6'h3E), .pin_in(pin_in));
	task finish_test;
		begin
			$display("checks %0d errors %0d", checks, err_total);
			if (err_total == 0 && checks > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// One single transfer; starts right after a rising edge
	task xfer(input w, input [7:0] a, input [31:0] d);
		begin
			if (!hclk)
				@(posedge hclk);
			htrans <= `PAX_HTRANS_NONSEQ;
			haddr <= {24'h0, a};
			hwrite <= w;
			@(posedge hclk);
			while (!hreadyout)
				@(posedge hclk);
			htrans <= 2'h0;
			hwdata <= d;
			@(posedge hclk);
			while (!hreadyout)
				@(posedge hclk);
			rd = hrdata;
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		xfer(1'h1, a, d);
	endtask
	task rc(input [7:0] a, input [31:0] e);
		begin
			xfer(1'h0, a, 32'h0);
			chk(rd, e);
		end
	endtask
	task wt;
		begin
			@(posedge hclk);
			@(negedge hclk);
		end
	endtask
	initial begin
		forever #2 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			err_total = err_total + 1;
			finish_test;
		end
	end
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rc(`PAX_OFS_ANA_LO, 32'hFF);
		rc(`PAX_OFS_ANA_HI, 32'hF);
		rc(`PAX_OFS_PULLUP, 32'h37);
		rc(`PAX_OFS_CHG_EN, 32'h0);
		rc(`PAX_OFS_DIR, 32'h3F);
		rc(`PAX_OFS_CTRL, 32'h1);
		rc(8'h40, 32'h0);
		chk(hresp, 32'h0);
		wr(`PAX_OFS_PULLUP, 32'hFFFFFFFF);
		wr(`PAX_OFS_CHG_EN, 32'hFF);
		wr(`PAX_OFS_ANA_HI, 32'hFF);
		rc(`PAX_OFS_PULLUP, 32'h37);
		rc(`PAX_OFS_CHG_EN, 32'h3F);
		rc(`PAX_OFS_ANA_HI, 32'hF);
		xtal <= 1'h1;
		wr(`PAX_OFS_PULLUP, 32'h0);
		wr(`PAX_OFS_CHG_EN, 32'h0);
		rc(`PAX_OFS_PULLUP, 32'h30);
		rc(`PAX_OFS_CHG_EN, 32'h30);
		xtal <= 1'h0;
		mc <= 1'h1;
		wr(`PAX_OFS_ANA_LO, 32'h0);
		wr(`PAX_OFS_PULLUP, 32'h37);
		wr(`PAX_OFS_CTRL, 32'h0);
		wt;
		chk(pullup_on, 32'h3F);
		wr(`PAX_OFS_CTRL, 32'h1);
		wt;
		chk(pullup_on, 32'h8);
		wr(`PAX_OFS_CTRL, 32'h0);
		wr(`PAX_OFS_DIR, 32'h3C);
		wt;
		chk(pullup_on, 32'h3C);
		chk(pin_oe, 32'h3);
		wr(`PAX_OFS_DIR, 32'h3F);
		wr(`PAX_OFS_ANA_LO, 32'h4);
		wt;
		chk(pullup_on, 32'h3B);
		rc(`PAX_OFS_PORT, 32'h32);
		mc <= 1'h0;
		wr(`PAX_OFS_CHG_EN, 32'h24);
		rc(`PAX_OFS_PORT, 32'h3A);
		wr(`PAX_OFS_STAT, 32'h1);
		ext_val <= 6'h3B;
		wt;
		rc(`PAX_OFS_STAT, 32'h0);
		ext_val <= 6'h1B;
		wt;
		rc(`PAX_OFS_STAT, 32'h3);
		sleep_mode <= 1'h1;
		wt;
		chk(wake_req, 32'h1);
		chk(int_req, 32'h0);
		wr(`PAX_OFS_CTRL, 32'h2);
		sleep_mode <= 1'h0;
		wt;
		chk(int_req, 32'h1);
		wr(`PAX_OFS_STAT, 32'h1);
		rc(`PAX_OFS_STAT, 32'h3);
		rc(`PAX_OFS_PORT, 32'h1A);
		rc(`PAX_OFS_STAT, 32'h1);
		wr(`PAX_OFS_STAT, 32'h1);
		rc(`PAX_OFS_STAT, 32'h0);
		ext_val <= 6'h3B;
		wt;
		@(posedge hclk);
		soft_rst <= 1'h1;
		@(posedge hclk);
		soft_rst <= 1'h0;
		rc(`PAX_OFS_STAT, 32'h1);
		rc(`PAX_OFS_CHG_EN, 32'h0);
		wr(`PAX_OFS_STAT, 32'h1);
		wr(`PAX_OFS_ANA_LO, 32'h0);
		wr(`PAX_OFS_PORT, 32'h1);
		wr(`PAX_OFS_DIR, 32'h3E);
		wt;
		chk(pin_out, 32'h1);
		wr(`PAX_OFS_DIR, 32'h3F);
		rc(`PAX_OFS_PORT, 32'h3B);
		wr(`PAX_OFS_CHG_EN, 32'h1);
		wr(`PAX_OFS_CTRL, 32'h6);
		wt;
		chk(wake_sink_on, 32'h1);
		chk(wake_req, 32'h0);
		@(posedge hclk);
		sleep_mode <= 1'h1;
		while (!wake_req)
			@(posedge hclk);
		wt;
		chk(pin_in[0], 32'h0);
		chk(int_req, 32'h1);
		finish_test;
	end
endmodule
